// *** hw/bsco_ctrl.sv ***
// design: backup switchover, clock output, stamp recorder and register port
`timescale 1ns/1ns
`default_nettype none
module bsco_ctrl import bsco_pkg::*; #(
	parameter int P_HALF_TICK_CYC = HALF_TICK_CYC
) (
	input wire logic i_clock,
	input wire logic i_sys_rst,
	input wire logic i_link_clock,
	input wire logic i_reg_req,
	input wire logic i_reg_write,
	input wire logic [7:0] i_reg_addr,
	input wire logic [7:0] i_reg_wdata,
	output logic o_reg_busy,
	output logic o_reg_done,
	output logic [7:0] o_reg_rdata,
	input wire logic i_main_low,
	input wire logic i_bat_above_main,
	input wire logic i_bat_low,
	input wire logic i_osc_stop,
	input wire logic i_event_input_pin,
	input wire logic i_clock_halt,
	input wire logic i_timer_pin_cfg,
	input wire logic i_stamp_irq_enable,
	input wire logic i_battery_low_stamp_enable,
	input wire bsco_cal_t i_calendar,
	input wire logic [2:0] i_stamp_index,
	output logic o_clock_out_pin,
	output logic o_clock_out_oe,
	output logic o_bus_enable,
	output logic o_main_supply_switch,
	output logic o_recharge_switch,
	output logic o_battery_switch,
	output logic o_backup_mode,
	output logic o_int_oe,
	output logic o_voltage_low_flag,
	output logic o_stamp_pulse,
	output logic [3:0] o_stamp_count,
	output bsco_stamp_t o_stamp_record
);
	bsco_main_t q;
	bsco_main_t n;
	bsco_link_t lq;
	bsco_link_t ln;
	bsco_stamp_t stamp_mem [STAMP_DEPTH];
	logic mem_we;
	logic [2:0] mem_idx;
	bsco_stamp_t mem_wdata;

	// sample-off length for a sample-time code
	function automatic logic [16:0] off_ticks(input logic [1:0] code);
		case (code)
			SMPT_2MS: off_ticks = OFF_2MS_TICKS;
			SMPT_128MS: off_ticks = OFF_128MS_TICKS;
			default: off_ticks = OFF_256MS_TICKS;
		endcase
	endfunction : off_ticks

	// status monitor byte, shared by register read and stamp snapshot
	function automatic logic [7:0] mon_byte(input bsco_main_t s);
		logic [7:0] m;
		m = 8'h00;
		m[MON_EVENT_INPUT_PIN] = s.s2.event_pin;
		m[MON_RECHARGE_COMPARE] = s.recharge_compare_stat;
		m[MON_BATTERY_LOW_STATUS] = s.battery_low_status_stat;
		mon_byte = m;
	endfunction : mon_byte

	// ---- link domain: takes host requests, hands them across by toggle
	always_comb begin
		ln = lq;
		ln.done = 1'b0;
		ln.ack_s1 = q.ack_tgl;
		ln.ack_s2 = lq.ack_s1;
		ln.bus_s1 = q.bus_en;
		ln.bus_s2 = lq.bus_s1;
		if (!lq.busy && i_reg_req && lq.bus_s2) begin
			ln.busy = 1'b1;
			ln.wr = i_reg_write;
			ln.addr = i_reg_addr;
			ln.wdata = i_reg_wdata;
			ln.req_tgl = ~lq.req_tgl;
		end else if (lq.busy && (lq.ack_s2 != lq.ack_seen)) begin
			// answer is held stable by the core until the next request
			ln.busy = 1'b0;
			ln.ack_seen = lq.ack_s2;
			ln.rdata = q.rdata;
			ln.done = 1'b1;
		end
	end

	// link domain register
	always_ff @(posedge i_link_clock or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			lq <= '0;
		end else begin
			lq <= ln;
		end
	end

	// ---- core domain
	always_comb begin
		logic tick;
		logic sec_wrap;
		logic poll_due;
		logic cmp_due;
		logic low_due;
		logic acc;
		logic host_trig;
		logic vlf_set;
		logic ini;
		logic chg;
		logic [1:0] swsel;
		logic [1:0] smpt;
		logic [1:0] fsel;
		logic src;
		logic on;
		logic stat_trig;
		logic evt_rise;
		logic tst_clear;
		logic [3:0] base;
		tick = 1'b0;
		sec_wrap = 1'b0;
		acc = 1'b0;
		host_trig = 1'b0;
		tst_clear = 1'b0;
		src = 1'b0;
		// every local starts defined, so no path can infer a latch
		poll_due = 1'b0;
		cmp_due = 1'b0;
		low_due = 1'b0;
		vlf_set = 1'b0;
		ini = 1'b0;
		chg = 1'b0;
		swsel = 2'h0;
		smpt = 2'h0;
		fsel = 2'h0;
		on = 1'b0;
		stat_trig = 1'b0;
		evt_rise = 1'b0;
		base = 4'h0;
		// state holds unless a branch below moves it
		n = q;
		n.stamp_pulse = 1'b0;
		mem_we = 1'b0;
		mem_idx = q.stamp_cnt[2:0];
		mem_wdata = '0;

		// two-stage synchronisers for pins and comparators
		n.s1 = {i_main_low, i_bat_above_main, i_bat_low, i_osc_stop, i_event_input_pin};
		n.s2 = q.s1;
		n.req_s1 = lq.req_tgl;
		n.req_s2 = q.req_s1;

		// crystal emulation: half ticks and a 16-bit phase over one second
		if (q.prescale == 16'(P_HALF_TICK_CYC - 1)) begin
			n.prescale = '0;
			tick = 1'b1;
		end else begin
			n.prescale = q.prescale + 16'h0001;
		end
		if (tick) begin
			n.phase = q.phase + 16'h0001;
			sec_wrap = (q.phase == 16'hFFFF);
			n.tri_cnt = (q.tri_cnt == BAT_PERIOD_TICKS - 18'h00001) ? '0 : q.tri_cnt + 18'h00001;
		end
		poll_due = tick && ((q.phase & (BACKUP_POLL_TICKS - 16'h0001)) == 16'h0000);
		cmp_due = tick && ((q.tri_cnt == '0) || (q.tri_cnt == CMP_HALF_TICKS));
		low_due = tick && (q.tri_cnt == '0);

		// register access handed over from the link side
		acc = (q.req_s2 != q.req_seen);
		if (acc) begin
			n.req_seen = q.req_s2;
			n.ack_tgl = ~q.ack_tgl;
			n.rdata = 8'h00;
			if (lq.wr) begin
				case (lq.addr)
					ADDR_EXT: n.ext = lq.wdata;
					ADDR_PSW: n.psw = lq.wdata;
					ADDR_TSTAT: tst_clear = 1'b1;
					ADDR_FLAG: begin
						// only a written zero clears; ones are ignored
						if (!lq.wdata[FLAG_VLF]) n.voltage_low_flag = 1'b0;
						if (!lq.wdata[FLAG_EVF]) n.evf = 1'b0;
					end
					default: ;
				endcase
			end else begin
				case (lq.addr)
					ADDR_EXT: n.rdata = q.ext;
					ADDR_PSW: n.rdata = q.psw;
					ADDR_MON: n.rdata = mon_byte(q);
					// flag bits placed one by one, no shift of a 1-bit value
					ADDR_FLAG: begin
						n.rdata[FLAG_VLF] = q.voltage_low_flag;
						n.rdata[FLAG_EVF] = q.evf;
					end
					// stamp status: full, empty and record count
					ADDR_TSTAT: begin
						n.rdata[TST_FULL] = (q.stamp_cnt == STAMP_FULL);
						n.rdata[TST_EMPTY] = (q.stamp_cnt == 4'h0);
						n.rdata[2:0] = q.stamp_cnt[2:0];
					end
					ADDR_TRIG: host_trig = 1'b1;
					default: n.rdata = 8'h00;
				endcase
			end
		end

		// voltage-low flag: oscillator stop sets, and the set beats a clear
		vlf_set = q.s2.osc_stop && !q.osc_prev;
		n.osc_prev = q.s2.osc_stop;
		if (vlf_set) n.voltage_low_flag = 1'b1;
		if (vlf_set && !q.voltage_low_flag) n.psw = PSW_RST;

		// supply switch mode
		ini = q.psw[PSW_INI];
		chg = q.psw[PSW_CHG] & ini;
		swsel = q.psw[PSW_SWSEL_LO +: 2];
		smpt = q.psw[PSW_SMPT_LO +: 2];
		case (q.pmode)
			PWR_FIXED: begin
				// detection suspended while automatic control is off
				if (ini) n.pmode = PWR_NORMAL;
			end
			PWR_NORMAL: begin
				if (!ini) begin
					n.pmode = PWR_FIXED;
				end else if (q.s2.main_low) begin
					n.pmode = PWR_BACKUP;
				end else if (sec_wrap && (smpt != SMPT_ON)) begin
					n.pmode = PWR_SAMPLE;
					n.off_cnt = '0;
				end
			end
			PWR_SAMPLE: begin
				if (!ini) begin
					n.pmode = PWR_FIXED;
				end else if (q.s2.main_low) begin
					n.pmode = PWR_BACKUP;
				end else if (tick) begin
					n.off_cnt = q.off_cnt + 17'h00001;
					if (q.off_cnt == off_ticks(smpt) - 17'h00001) n.pmode = PWR_NORMAL;
				end
			end
			PWR_BACKUP: begin
				// main supply re-checked only on the slow poll
				if (poll_due && !q.s2.main_low) n.pmode = PWR_NORMAL;
			end
			default: n.pmode = PWR_FIXED;
		endcase

		// switch drive from the next mode
		case (n.pmode)
			PWR_FIXED: begin
				n.sw_main = (swsel == SWSEL_MAIN);
				n.sw_bat = (swsel != SWSEL_MAIN);
				n.sw_rech = 1'b0;
			end
			PWR_NORMAL: begin
				n.sw_main = 1'b1;
				n.sw_bat = 1'b0;
				n.sw_rech = chg && !q.recharge_compare_stat;
			end
			PWR_BACKUP: begin
				n.sw_main = 1'b0;
				n.sw_bat = 1'b1;
				n.sw_rech = 1'b0;
			end
			default: begin
				n.sw_main = 1'b0;
				n.sw_bat = 1'b0;
				n.sw_rech = 1'b0;
			end
		endcase
		n.bus_en = (n.pmode != PWR_BACKUP);
		// backup indication kept in a flop so the pin has no decode glitch
		n.backup = (n.pmode == PWR_BACKUP);

		// recharge compare and battery-low filter
		if (cmp_due && chg && (q.pmode == PWR_NORMAL)) n.recharge_compare_stat = q.s2.bat_above;
		if (low_due) begin
			n.battery_low_status_last = q.s2.bat_low;
			if (q.s2.bat_low == q.battery_low_status_last) n.battery_low_status_stat = q.s2.bat_low;
		end

		// clock output selection
		fsel = q.ext[EXT_FSEL_LO +: 2];
		case (fsel)
			FSEL_32K: src = q.phase[PH_32K];
			FSEL_1K: src = q.phase[PH_1K];
			FSEL_1HZ: src = q.phase[PH_1HZ];
			default: src = 1'b0;
		endcase
		on = (fsel != FSEL_OFF) && !((fsel == FSEL_1HZ) && i_clock_halt)
			&& (n.pmode != PWR_BACKUP) && !i_timer_pin_cfg;
		n.clk_oe = on;
		n.clk_out = on && src;

		// stamp triggers and recording
		evt_rise = q.s2.event_pin && !q.evt_prev;
		n.evt_prev = q.s2.event_pin;
		stat_trig = i_battery_low_stamp_enable && n.battery_low_status_stat && !q.battery_low_status_stat;
		base = tst_clear ? 4'h0 : q.stamp_cnt;
		n.stamp_cnt = base;
		if ((evt_rise || stat_trig || host_trig) && (base != STAMP_FULL)) begin
			mem_we = 1'b1;
			mem_idx = base[2:0];
			mem_wdata.subsec = q.phase[PH_SUB_LSB +: 7];
			mem_wdata.cal = i_calendar;
			mem_wdata.status = mon_byte(q);
			n.stamp_cnt = base + 4'h1;
			n.stamp_pulse = 1'b1;
			n.evf = 1'b1;
		end
		// interrupt held while the event flag stands
		n.int_oe = n.evf && (q.int_oe || (n.stamp_pulse && i_stamp_irq_enable));
		n.rec_out = stamp_mem[i_stamp_index];
	end

	// core domain register; power-on sets the voltage-low flag
	always_ff @(posedge i_clock or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			q <= '0;
			q.voltage_low_flag <= 1'b1;
			q.ext <= EXT_RST;
			q.psw <= PSW_RST;
			q.sw_bat <= 1'b1;
			q.bus_en <= 1'b1;
		end else begin
			q <= n;
		end
	end

	// stamp record memory
	always_ff @(posedge i_clock) begin
		if (mem_we) begin
			stamp_mem[mem_idx] <= mem_wdata;
		end
	end

	// outputs straight from state
	assign o_reg_busy = lq.busy;
	assign o_reg_done = lq.done;
	assign o_reg_rdata = lq.rdata;
	assign o_clock_out_pin = q.clk_out;
	assign o_clock_out_oe = q.clk_oe;
	assign o_bus_enable = q.bus_en;
	assign o_main_supply_switch = q.sw_main;
	assign o_recharge_switch = q.sw_rech;
	assign o_battery_switch = q.sw_bat;
	assign o_backup_mode = q.backup;
	assign o_int_oe = q.int_oe;
	assign o_voltage_low_flag = q.voltage_low_flag;
	assign o_stamp_pulse = q.stamp_pulse;
	assign o_stamp_count = q.stamp_cnt;
	assign o_stamp_record = q.rec_out;
endmodule : bsco_ctrl
`default_nettype wire

// *** hw/bsco_pkg.sv ***
// package: register map, field layout, timing and carriers for backup switch and clock output
package bsco_pkg;
	// timebase: a half tick is one edge of the 32.768 kHz crystal
	localparam int CLK_HZ = 50000000;
	localparam int OSC_HZ = 32768;
	localparam int HALF_TICK_CYC = CLK_HZ / (2 * OSC_HZ);
	localparam longint TICKS_PER_S = 2 * OSC_HZ;
	localparam longint US_PER_S = 1000000;
	localparam longint MS_PER_S = 1000;
	// sample-off intervals, least times rounded up
	localparam longint OFF_2MS_US = 2000;
	localparam longint OFF_128MS_US = 128000;
	localparam longint OFF_256MS_US = 256000;
	localparam logic [16:0] OFF_2MS_TICKS = 17'((OFF_2MS_US * TICKS_PER_S + US_PER_S - 1) / US_PER_S);
	localparam logic [16:0] OFF_128MS_TICKS =
		17'((OFF_128MS_US * TICKS_PER_S + US_PER_S - 1) / US_PER_S);
	localparam logic [16:0] OFF_256MS_TICKS =
		17'((OFF_256MS_US * TICKS_PER_S + US_PER_S - 1) / US_PER_S);
	// supply polling periods
	localparam longint BACKUP_POLL_US = 31250;
	localparam logic [15:0] BACKUP_POLL_TICKS = 16'((BACKUP_POLL_US * TICKS_PER_S) / US_PER_S);
	localparam longint BAT_PERIOD_MS = 3000;
	localparam logic [17:0] BAT_PERIOD_TICKS = 18'((BAT_PERIOD_MS * TICKS_PER_S) / MS_PER_S);
	localparam logic [17:0] CMP_HALF_TICKS = 18'((BAT_PERIOD_MS * TICKS_PER_S) / (2 * MS_PER_S));
	// phase bits that carry each output frequency, and the stamp sub-second low bit
	localparam int PH_32K = 0;
	localparam int PH_1K = 5;
	localparam int PH_1HZ = 15;
	localparam int PH_SUB_LSB = 9;
	// register addresses
	localparam logic [7:0] ADDR_EXT = 8'h1D;
	localparam logic [7:0] ADDR_FLAG = 8'h1E;
	localparam logic [7:0] ADDR_TRIG = 8'h2F;
	localparam logic [7:0] ADDR_PSW = 8'h32;
	localparam logic [7:0] ADDR_MON = 8'h33;
	localparam logic [7:0] ADDR_TSTAT = 8'h36;
	// field positions
	localparam int EXT_FSEL_LO = 6;
	localparam int FLAG_EVF = 2;
	localparam int FLAG_VLF = 1;
	localparam int PSW_CHG = 7;
	localparam int PSW_INI = 6;
	localparam int PSW_SWSEL_LO = 2;
	localparam int PSW_SMPT_LO = 0;
	localparam int MON_EVENT_INPUT_PIN = 6;
	localparam int MON_RECHARGE_COMPARE = 3;
	localparam int MON_BATTERY_LOW_STATUS = 1;
	localparam int TST_FULL = 4;
	localparam int TST_EMPTY = 3;
	// reset values
	localparam logic [7:0] EXT_RST = 8'h00;
	localparam logic [7:0] PSW_RST = 8'h04;
	// field codes
	localparam logic [1:0] FSEL_32K = 2'h0;
	localparam logic [1:0] FSEL_1K = 2'h1;
	localparam logic [1:0] FSEL_1HZ = 2'h2;
	localparam logic [1:0] FSEL_OFF = 2'h3;
	localparam logic [1:0] SWSEL_MAIN = 2'h2;
	localparam logic [1:0] SMPT_ON = 2'h0;
	localparam logic [1:0] SMPT_2MS = 2'h1;
	localparam logic [1:0] SMPT_128MS = 2'h2;
	// stamp memory
	localparam int STAMP_DEPTH = 8;
	localparam logic [3:0] STAMP_FULL = 4'h8;

	typedef enum logic [1:0] {PWR_FIXED, PWR_NORMAL, PWR_SAMPLE, PWR_BACKUP} bsco_pmode_t;

	typedef struct packed {
		logic [7:0] year;
		logic [7:0] month;
		logic [7:0] day;
		logic [7:0] hour;
		logic [7:0] minute;
		logic [7:0] second;
	} bsco_cal_t;

	typedef struct packed {
		logic [6:0] subsec;
		bsco_cal_t cal;
		logic [7:0] status;
	} bsco_stamp_t;

	// analog and pin inputs, in sync-chain order
	typedef struct packed {
		logic main_low;
		logic bat_above;
		logic bat_low;
		logic osc_stop;
		logic event_pin;
	} bsco_sense_t;

	typedef struct packed {
		logic [15:0] prescale;
		logic [15:0] phase;
		logic [17:0] tri_cnt;
		logic [16:0] off_cnt;
		bsco_pmode_t pmode;
		logic [7:0] ext;
		logic [7:0] psw;
		logic voltage_low_flag;
		logic evf;
		bsco_sense_t s1;
		bsco_sense_t s2;
		logic osc_prev;
		logic evt_prev;
		logic recharge_compare_stat;
		logic battery_low_status_stat;
		logic battery_low_status_last;
		logic req_s1;
		logic req_s2;
		logic req_seen;
		logic ack_tgl;
		logic [7:0] rdata;
		logic [3:0] stamp_cnt;
		bsco_stamp_t rec_out;
		logic stamp_pulse;
		logic int_oe;
		logic clk_out;
		logic clk_oe;
		logic bus_en;
		logic sw_main;
		logic sw_rech;
		logic sw_bat;
		logic backup;
	} bsco_main_t;

	typedef struct packed {
		logic busy;
		logic wr;
		logic [7:0] addr;
		logic [7:0] wdata;
		logic req_tgl;
		logic ack_s1;
		logic ack_s2;
		logic ack_seen;
		logic bus_s1;
		logic bus_s2;
		logic [7:0] rdata;
		logic done;
	} bsco_link_t;
endpackage : bsco_pkg

// *** tb/bsco_ctrl_tb.sv ***
// bench: register port sequences for clock output, switchover and stamps
`timescale 1ns/1ns
`default_nettype none
module bsco_ctrl_tb import bsco_pkg::*; ;
	localparam int HT = 2;
	logic i_clock = 1'b0, i_link_clock = 1'b0, rst = 1'b1;
	logic req, wr, busy, done, ok, pin, oe, bus_en, sw_main, sw_rech, sw_bat, bk, int_oe, voltage_low_flag, pulse;
	logic [7:0] addr, wdata, rdata, rd;
	logic main_low = 1'b0, bat_above = 1'b0, bat_low = 1'b0, osc_stop = 1'b0, evt = 1'b0;
	logic halt = 1'b0, tcfg = 1'b0, irq_en = 1'b1, low_en = 1'b0;
	logic [2:0] idx = 3'h0;
	logic [3:0] cnt;
	bsco_cal_t cal = 48'h240B15083024;
	bsco_stamp_t rec;
	int mismatches = 0, check_count = 0, cyc_n = 0, t, tc, e, n;
	logic [7:0] pv [5] = '{8'h08, 8'h00, 8'h80, 8'h40, 8'hC0};
	logic [2:0] pe [5] = '{3'h4, 3'h1, 3'h1, 3'h4, 3'h6};
	bsco_ctrl #(.P_HALF_TICK_CYC(HT)) bsco_ctrl_i (.i_clock(i_clock), .i_sys_rst(rst),
		.i_link_clock(i_link_clock), .i_reg_req(req), .i_reg_write(wr), .i_reg_addr(addr),
		.i_reg_wdata(wdata), .o_reg_busy(busy), .o_reg_done(done), .o_reg_rdata(rdata),
		.i_main_low(main_low), .i_bat_above_main(bat_above), .i_bat_low(bat_low),
		.i_osc_stop(osc_stop), .i_event_input_pin(evt), .i_clock_halt(halt),
		.i_timer_pin_cfg(tcfg), .i_stamp_irq_enable(irq_en), .i_battery_low_stamp_enable(low_en),
		.i_calendar(cal), .i_stamp_index(idx), .o_clock_out_pin(pin), .o_clock_out_oe(oe),
		.o_bus_enable(bus_en), .o_main_supply_switch(sw_main), .o_recharge_switch(sw_rech),
		.o_battery_switch(sw_bat), .o_backup_mode(bk), .o_int_oe(int_oe),
		.o_voltage_low_flag(voltage_low_flag), .o_stamp_pulse(pulse), .o_stamp_count(cnt),
		.o_stamp_record(rec));
	bsco_host bsco_host_i (.i_link_clock(i_link_clock), .i_busy(busy), .i_done(done),
		.i_rdata(rdata), .o_req(req), .o_write(wr), .o_addr(addr), .o_wdata(wdata));
	// core and link clocks, unrelated in phase
	always #10 i_clock = ~i_clock;
	always #24 i_link_clock = ~i_link_clock;
	// hang guard
	always @(posedge i_clock) begin
		cyc_n++;
		if (cyc_n == 20000) begin
			mismatches++;
			complete_run();
		end
	end
	task automatic complete_run();
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : complete_run
	task automatic check_bit(input logic act, input logic exp);
		check_count++;
		if (act !== exp) begin
			mismatches++;
			$display("mismatch at %0t: got %0h expected %0h", $time, act, exp);
		end
	endtask : check_bit
	task automatic check_byte(input logic [7:0] act, input logic [7:0] exp);
		check_count++;
		if (act !== exp) begin
			mismatches++;
			$display("mismatch at %0t: got %0h expected %0h", $time, act, exp);
		end
	endtask : check_byte
	task automatic cyc(input int k);
		repeat (k) @(posedge i_clock);
		#2;
	endtask : cyc
	task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
		bsco_host_i.xfer(1'b1, a, d, rd, ok);
		check_bit(ok, 1'b1);
	endtask : reg_wr
	task automatic reg_rd(input logic [7:0] a, input logic [7:0] x);
		bsco_host_i.xfer(1'b0, a, 8'h00, rd, ok);
		check_bit(ok, 1'b1);
		check_byte(rd, x);
	endtask : reg_rd
	// edges of the output pin over 256 core cycles
	task automatic count_toggles(output int k);
		logic last;
		k = 0;
		last = pin;
		repeat (256) begin
			@(posedge i_clock);
			#1;
			if (pin !== last) k++;
			last = pin;
		end
		#2;
	endtask : count_toggles
	task automatic wait_backup(input logic v, input int lim);
		n = 0;
		while (bk !== v && n < lim) begin cyc(1); n++; end
		check_bit(bk, v);
	endtask : wait_backup
	task automatic end_test(input string s);
		$display("test %s done", s);
	endtask : end_test
	// main sequence
	initial begin
		repeat (3) @(posedge i_link_clock);
		#2;
		rst = 1'b0;
		repeat (3) @(posedge i_link_clock);
		reg_rd(ADDR_EXT, EXT_RST);
		reg_rd(ADDR_PSW, PSW_RST);
		check_byte(8'({sw_main, sw_rech, sw_bat}), 8'h01);
		reg_wr(8'h40, 8'hFF);
		reg_rd(8'h40, 8'h00);
		end_test("reset");
		halt = 1'b1;
		for (int c = 0; c < 4; c++) begin
			reg_wr(ADDR_EXT, {2'(c), 6'h00});
			cyc(4);
			count_toggles(t);
			e = (c == 0) ? 256 / HT : (c == 1) ? 256 / (HT << PH_1K) : 0;
			tc = (t >= e - 1 && t <= e + 1) ? e : t;
			check_byte(8'(tc), 8'(e));
			check_bit(oe, c < 2);
		end
		halt = 1'b0;
		reg_wr(ADDR_EXT, 8'h00);
		tcfg = 1'b1;
		cyc(3);
		check_bit(oe, 1'b0);
		tcfg = 1'b0;
		cyc(3);
		check_bit(oe, 1'b1);
		end_test("clock out");
		for (int k = 0; k < 5; k++) begin
			reg_wr(ADDR_PSW, pv[k]);
			cyc(4);
			check_byte(8'({sw_main, sw_rech, sw_bat}), 8'(pe[k]));
			reg_rd(ADDR_PSW, pv[k]);
		end
		end_test("switches");
		main_low = 1'b1;
		wait_backup(1'b1, 20);
		cyc(1);
		check_byte(8'({bus_en, oe, sw_bat, sw_main}), 8'h02);
		bsco_host_i.xfer(1'b0, ADDR_PSW, 8'h00, rd, ok);
		check_bit(ok, 1'b0);
		evt = 1'b1;
		cyc(8);
		check_byte(8'(cnt), 8'h01);
		check_bit(int_oe, 1'b1);
		main_low = 1'b0;
		evt = 1'b0;
		wait_backup(1'b0, 6000);
		repeat (3) @(posedge i_link_clock);
		end_test("backup");
		reg_rd(ADDR_TRIG, 8'h00);
		cyc(4);
		check_byte(8'(cnt), 8'h02);
		idx = 3'h1;
		cyc(2);
		check_bit(rec.cal === cal, 1'b1);
		for (int k = 0; k < 7; k++) reg_rd(ADDR_TRIG, 8'h00);
		cyc(4);
		check_byte(8'(cnt), 8'(STAMP_FULL));
		reg_rd(ADDR_TSTAT, 8'h10);
		reg_rd(ADDR_FLAG, 8'h06);
		reg_wr(ADDR_FLAG, 8'h00);
		cyc(2);
		check_bit(int_oe, 1'b0);
		reg_wr(ADDR_FLAG, 8'h02);
		reg_rd(ADDR_FLAG, 8'h00);
		reg_wr(ADDR_TSTAT, 8'h00);
		reg_rd(ADDR_TSTAT, 8'h08);
		end_test("stamps");
		reg_wr(ADDR_PSW, 8'hC1);
		osc_stop = 1'b1;
		cyc(8);
		check_bit(voltage_low_flag, 1'b1);
		reg_rd(ADDR_PSW, PSW_RST);
		check_byte(8'({sw_main, sw_rech, sw_bat}), 8'h01);
		osc_stop = 1'b0;
		end_test("voltage low");
		complete_run();
	end
endmodule : bsco_ctrl_tb
`default_nettype wire

// *** tb/bsco_host.sv ***
// host model: one byte transfer at a time on the register port
`timescale 1ns/1ns
`default_nettype none
module bsco_host (
	input wire logic i_link_clock,
	input wire logic i_busy,
	input wire logic i_done,
	input wire logic [7:0] i_rdata,
	output logic o_req,
	output logic o_write,
	output logic [7:0] o_addr,
	output logic [7:0] o_wdata
);
	// idle port at time zero
	initial begin
		o_req = 1'b0;
		o_write = 1'b0;
		o_addr = 8'h00;
		o_wdata = 8'h00;
	end
	// request held until taken, fields until answered; ok low if refused
	task automatic xfer(input logic wr, input logic [7:0] a, input logic [7:0] d,
		output logic [7:0] rd, output logic ok);
		int n;
		n = 0;
		@(posedge i_link_clock);
		#2;
		o_req = 1'b1;
		o_write = wr;
		o_addr = a;
		o_wdata = d;
		do begin @(posedge i_link_clock); #1; n++; end while (i_busy !== 1'b1 && n < 20);
		#1;
		o_req = 1'b0;
		while (i_done !== 1'b1 && n < 40) begin @(posedge i_link_clock); #1; n++; end
		rd = i_rdata;
		ok = (i_done === 1'b1);
	endtask : xfer
endmodule : bsco_host
`default_nettype wire

// *** tb/bsco_sva.sv ***
// checker: port-level properties of the switchover and clock output block
`timescale 1ns/1ns
`default_nettype none
module bsco_sva import bsco_pkg::*; (
	input wire logic i_clock,
	input wire logic i_sys_rst,
	input wire logic i_link_clock,
	input wire logic i_main_low,
	input wire logic i_osc_stop,
	input wire logic i_timer_pin_cfg,
	input wire logic i_stamp_irq_enable,
	input wire logic o_reg_busy,
	input wire logic o_reg_done,
	input wire logic o_clock_out_pin,
	input wire logic o_clock_out_oe,
	input wire logic o_bus_enable,
	input wire logic o_main_supply_switch,
	input wire logic o_recharge_switch,
	input wire logic o_battery_switch,
	input wire logic o_backup_mode,
	input wire logic o_int_oe,
	input wire logic o_voltage_low_flag,
	input wire logic o_stamp_pulse,
	input wire logic [3:0] o_stamp_count
);
	// switch state of a fresh power switch register
	sequence s_psw_default;
		o_battery_switch && !o_main_supply_switch && !o_recharge_switch;
	endsequence
	// backup held for two cycles
	sequence s_in_backup;
		o_backup_mode && $past(o_backup_mode);
	endsequence
	a_backup_float: assert property (@(posedge i_clock) disable iff (i_sys_rst)
		s_in_backup |-> !o_clock_out_oe && !o_bus_enable) else $error("backup left pin or bus on");
	a_backup_switch: assert property (@(posedge i_clock) disable iff (i_sys_rst)
		s_in_backup |-> s_psw_default) else $error("backup switch state wrong");
	a_backup_cause: assert property (@(posedge i_clock) disable iff (i_sys_rst)
		$rose(o_backup_mode) |-> $past(i_main_low, 2) && $past(i_main_low, 3))
		else $error("backup without main low");
	a_timer_float: assert property (@(posedge i_clock) disable iff (i_sys_rst)
		i_timer_pin_cfg && $past(i_timer_pin_cfg) |-> !o_clock_out_oe) else $error("pin driven");
	a_float_low: assert property (@(posedge i_clock) disable iff (i_sys_rst)
		!o_clock_out_oe |-> !o_clock_out_pin) else $error("floating pin not low");
	a_recharge_mode: assert property (@(posedge i_clock) disable iff (i_sys_rst)
		o_recharge_switch |-> !o_backup_mode && !o_battery_switch) else $error("recharge bad mode");
	a_stamp_step: assert property (@(posedge i_clock) disable iff (i_sys_rst)
		o_stamp_pulse |-> o_stamp_count == $past(o_stamp_count) + 4'h1) else $error("count step");
	a_stamp_limit: assert property (@(posedge i_clock) disable iff (i_sys_rst)
		o_stamp_count <= STAMP_FULL) else $error("count above full");
	a_stamp_irq: assert property (@(posedge i_clock) disable iff (i_sys_rst)
		o_stamp_pulse && i_stamp_irq_enable |-> ##[0:1] o_int_oe) else $error("no stamp irq");
	a_osc_flag: assert property (@(posedge i_clock) disable iff (i_sys_rst)
		$rose(i_osc_stop) |-> ##[1:6] o_voltage_low_flag) else $error("flag not set");
	a_flag_default: assert property (@(posedge i_clock) disable iff (i_sys_rst)
		$rose(o_voltage_low_flag) |-> ##[0:3] s_psw_default) else $error("switch not default");
	a_done_pulse: assert property (@(posedge i_link_clock) disable iff (i_sys_rst)
		o_reg_done |=> !o_reg_done) else $error("done longer than one cycle");
	a_busy_answer: assert property (@(posedge i_link_clock) disable iff (i_sys_rst)
		$fell(o_reg_busy) |-> o_reg_done) else $error("busy fell without done");
endmodule : bsco_sva
bind bsco_ctrl bsco_sva bsco_sva_i (.i_clock, .i_sys_rst, .i_link_clock, .i_main_low,
	.i_osc_stop, .i_timer_pin_cfg, .i_stamp_irq_enable, .o_reg_busy, .o_reg_done,
	.o_clock_out_pin, .o_clock_out_oe, .o_bus_enable, .o_main_supply_switch,
	.o_recharge_switch, .o_battery_switch, .o_backup_mode, .o_int_oe,
	.o_voltage_low_flag, .o_stamp_pulse, .o_stamp_count);
`default_nettype wire
